// >>> verilog/pio_pkg.sv
package pio_pkg;
	localparam int          INSTR_W     = 10;
	localparam int          NIB_W       = 4;
	localparam int          NUM_PORTS   = 4;
	localparam int          SYNC_STAGES = 2;
	localparam int          PSEL_W      = 2;
	localparam int          IMM_PREF_W  = 6;

	// Port input family: upper eight bits fixed, low two bits pick the port
	localparam logic [INSTR_W-1:0]    IN_PORT_MASK = 10'h3FC;
	localparam logic [INSTR_W-1:0]    IN_PORT_BASE = 10'h260;
	localparam logic [INSTR_W-1:0]    IN_PORT0     = 10'h260;
	localparam logic [INSTR_W-1:0]    IN_PORT1     = 10'h261;
	localparam logic [INSTR_W-1:0]    IN_PORT2     = 10'h262;
	localparam logic [INSTR_W-1:0]    IN_PORT3     = 10'h263;

	// Immediate load: upper six bits fixed, low four bits carry the value
	localparam logic [IMM_PREF_W-1:0] LOAD_IMM_PREF = 6'h07;
	localparam int                    IMM_LSB       = 0;
	localparam int                    PREF_LSB      = 4;

	// Skip-on-Y-zero opcode; default value is arbitrary, override per core
	localparam logic [INSTR_W-1:0]    SKIP_Y_ZERO_CODE = 10'h3F0;

	localparam logic [NIB_W-1:0]      ACC_RST   = 4'h0;
	localparam logic                  CARRY_RST = 1'b0;
	localparam logic [NIB_W-1:0]      Y_ZERO    = 4'h0;

	typedef enum logic [2:0] {
		PIO_OP_OTHER  = 3'b000,
		PIO_OP_IN     = 3'b001,
		PIO_OP_LDI    = 3'b011,
		PIO_OP_SKIP_Y = 3'b010
	} pio_op_e;
endpackage

// >>> verilog/pio_sync.sv
`timescale 1ns/100ps
module pio_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_q
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	// First stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always_comb begin
				meta_d[i] = async_in[i];
				sync_d[i] = meta_q[i];
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end
endmodule

// >>> verilog/pio_core.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Port zero input op loads accumulator
// - Port one input op loads accumulator
// - Port two input op loads accumulator
// - Port three input op loads accumulator
// - Skip next instruction when Y is zero
// - Immediate op loads value into accumulator, unless the previous valid word was also an immediate load
module pio_core #(
	parameter logic [pio_pkg::INSTR_W-1:0] SKIP_CODE = pio_pkg::SKIP_Y_ZERO_CODE
) (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        instr_valid,
	input  wire logic [pio_pkg::INSTR_W-1:0] instr_word,
	input  wire logic [pio_pkg::NIB_W-1:0]   port_zero,
	input  wire logic [pio_pkg::NIB_W-1:0]   port_one,
	input  wire logic [pio_pkg::NIB_W-1:0]   port_two,
	input  wire logic [pio_pkg::NIB_W-1:0]   port_three,
	input  wire logic [pio_pkg::NIB_W-1:0]   y_value,
	input  wire logic                        acc_wr_en,
	input  wire logic [pio_pkg::NIB_W-1:0]   acc_wr_data,
	input  wire logic                        carry_wr_en,
	input  wire logic                        carry_wr_data,
	output logic      [pio_pkg::NIB_W-1:0]   acc_q,
	output logic                             carry_flag_q,
	output logic                             skip_next_q,
	output logic                             executed_q,
	output logic                             skipped_q
);
	import pio_pkg::*;

	localparam int PORT_BITS = NUM_PORTS * NIB_W;

	logic [PORT_BITS-1:0] port_raw;
	logic [PORT_BITS-1:0] port_sync;
	logic [NIB_W-1:0]     port_nib [NUM_PORTS];

	pio_op_e              op;
	logic [PSEL_W-1:0]    port_sel;
	logic [NIB_W-1:0]     imm_val;
	logic                 ldi_word;
	logic                 skip_hit;
	logic                 run_la;
	logic                 do_skip;
	logic                 do_exec;

	logic [NIB_W-1:0]     acc_d;
	logic                 carry_flag_d;
	logic                 skip_next_d;
	logic                 executed_d;
	logic                 skipped_d;
	logic                 last_la_q;
	logic                 last_la_d;

	// Classifies one instruction word; used for the op and for the run check
	function automatic pio_op_e decode_op(input logic [INSTR_W-1:0] w,
					      input logic [INSTR_W-1:0] skip_code);
		pio_op_e r;
		r = PIO_OP_OTHER;
		if ((w & IN_PORT_MASK) == IN_PORT_BASE) begin
			r = PIO_OP_IN;
		end else if (w[INSTR_W-1:PREF_LSB] == LOAD_IMM_PREF) begin
			r = PIO_OP_LDI;
		end else if (w == skip_code) begin
			r = PIO_OP_SKIP_Y;
		end
		return r;
	endfunction

	function automatic logic is_load_imm(input logic [INSTR_W-1:0] w,
					     input logic [INSTR_W-1:0] skip_code);
		return decode_op(w, skip_code) == PIO_OP_LDI;
	endfunction

	// Pins are asynchronous; two-stage latency before the accumulator sees them
	always_comb begin
		port_raw = {port_three, port_two, port_one, port_zero};
	end

	pio_sync #(
		.WIDTH(PORT_BITS)
	) u_port_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (port_raw),
		.sync_q   (port_sync)
	);

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
			always_comb begin
				port_nib[p] = port_sync[p*NIB_W +: NIB_W];
			end
		end
	endgenerate

	always_comb begin
		op       = decode_op(instr_word, SKIP_CODE);
		port_sel = instr_word[PSEL_W-1:0];
		imm_val  = instr_word[IMM_LSB +: NIB_W];
		ldi_word = is_load_imm(instr_word, SKIP_CODE);
		skip_hit = (op == PIO_OP_SKIP_Y) && (y_value == Y_ZERO);
		// Later immediate loads in a run never execute
		run_la   = ldi_word && last_la_q;
		do_skip  = instr_valid && (skip_next_q || run_la);
		do_exec  = instr_valid && !do_skip;
	end

	// Accumulator
	always_comb begin
		acc_d = acc_q;
		if (acc_wr_en) begin
			acc_d = acc_wr_data;
		end
		// Own port and immediate loads win over an outside write in the same cycle
		if (do_exec) begin
			case (op)
				PIO_OP_IN: begin
					case (port_sel)
						2'h0: begin
							acc_d = port_nib[0];
						end
						2'h1: begin
							acc_d = port_nib[1];
						end
						2'h2: begin
							acc_d = port_nib[2];
						end
						default: begin
							acc_d = port_nib[3];
						end
					endcase
				end
				PIO_OP_LDI: begin
					acc_d = imm_val;
				end
				default: begin
					acc_d = acc_d;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_q <= ACC_RST;
		end else begin
			acc_q <= acc_d;
		end
	end

	// Carry: only outside writes move it, none of these ops touch it
	always_comb begin
		carry_flag_d = carry_flag_q;
		if (carry_wr_en) begin
			carry_flag_d = carry_wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			carry_flag_q <= CARRY_RST;
		end else begin
			carry_flag_q <= carry_flag_d;
		end
	end

	// Skip flag: any valid word consumes it, so a skipped skip op never sets it
	always_comb begin
		skip_next_d = skip_next_q;
		if (instr_valid) begin
			skip_next_d = 1'h0;
			if (do_exec && skip_hit) begin
				skip_next_d = 1'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			skip_next_q <= 1'h0;
		end else begin
			skip_next_q <= skip_next_d;
		end
	end

	// Run tracker: a skipped word still counts toward an immediate-load run
	always_comb begin
		last_la_d = last_la_q;
		if (instr_valid) begin
			last_la_d = ldi_word;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			last_la_q <= 1'h0;
		end else begin
			last_la_q <= last_la_d;
		end
	end

	// Status pulses last one cycle; idle cycles show neither
	always_comb begin
		executed_d = 1'h0;
		skipped_d  = 1'h0;
		if (instr_valid) begin
			executed_d = do_exec;
			skipped_d  = do_skip;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			executed_q <= 1'h0;
			skipped_q  <= 1'h0;
		end else begin
			executed_q <= executed_d;
			skipped_q  <= skipped_d;
		end
	end
endmodule

// >>> dv/pio_core_assertions.sv
`timescale 1ns/100ps
module pio_chk
	import pio_pkg::*;
#(
	parameter logic [9:0] SKIP_CODE = SKIP_Y_ZERO_CODE
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       instr_valid,
	input wire logic [9:0] instr_word,
	input wire logic [3:0] port_zero,
	input wire logic [3:0] port_one,
	input wire logic [3:0] port_two,
	input wire logic [3:0] port_three,
	input wire logic [3:0] y_value,
	input wire logic       carry_wr_en,
	input wire logic [3:0] acc_q,
	input wire logic       carry_flag_q,
	input wire logic       skip_next_q,
	input wire logic       executed_q,
	input wire logic       skipped_q
);
	logic ldi;
	logic go;
	logic prev_ldi_q;
	assign ldi = instr_word[9:4] == LOAD_IMM_PREF;
	assign go = instr_valid && !skip_next_q;
	// Idle cycles keep the run open
	always_ff @(posedge clk) begin
		if (!rst_n) prev_ldi_q <= 1'b0;
		else if (instr_valid) prev_ldi_q <= ldi;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Pins pass two sync flops, so three edges back
	property p_in(logic [1:0] k, logic [3:0] pin);
		go && instr_word == (IN_PORT_BASE | k) && $past(rst_n, 2) && $past(rst_n) |=> acc_q == $past(pin, 3);
	endproperty
	a_in0: assert property (p_in(0, port_zero)) else $error("port zero read");
	a_in1: assert property (p_in(1, port_one)) else $error("port one read");
	a_in2: assert property (p_in(2, port_two)) else $error("port two read");
	a_in3: assert property (p_in(3, port_three)) else $error("port three read");
	property p_carry;
		!carry_wr_en |=> $stable(carry_flag_q);
	endproperty
	a_carry: assert property (p_carry) else $error("carry moved");
	property p_skip_set;
		go && instr_word == SKIP_CODE && y_value == Y_ZERO |=> skip_next_q;
	endproperty
	a_skip_set: assert property (p_skip_set) else $error("skip not set");
	property p_skip_clr;
		go && instr_word == SKIP_CODE && y_value != Y_ZERO |=> !skip_next_q;
	endproperty
	a_skip_clr: assert property (p_skip_clr) else $error("skip set");
	property p_skip_use;
		instr_valid && skip_next_q |=> skipped_q && !skip_next_q && !executed_q;
	endproperty
	a_skip_use: assert property (p_skip_use) else $error("skip not taken");
	property p_ldi;
		go && ldi && !prev_ldi_q |=> acc_q == $past(instr_word[3:0]) && executed_q;
	endproperty
	a_ldi: assert property (p_ldi) else $error("immediate load");
	property p_run;
		instr_valid && ldi && prev_ldi_q |=> skipped_q && !executed_q;
	endproperty
	a_run: assert property (p_run) else $error("run not skipped");
	c_skip: cover property (go && instr_word == SKIP_CODE && y_value == Y_ZERO);
	c_run: cover property (instr_valid && ldi && prev_ldi_q);
	c_in: cover property (go && instr_word == IN_PORT3);
endmodule

bind pio_core pio_chk #(.SKIP_CODE(SKIP_CODE)) pio_chk_i (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
	.instr_word(instr_word), .port_zero(port_zero), .port_one(port_one), .port_two(port_two),
	.port_three(port_three), .y_value(y_value), .carry_wr_en(carry_wr_en), .acc_q(acc_q),
	.carry_flag_q(carry_flag_q), .skip_next_q(skip_next_q), .executed_q(executed_q), .skipped_q(skipped_q));

// >>> dv/pio_core_tb.sv
`timescale 1ns/100ps
module pio_core_tb;
	import pio_pkg::*;
	logic       clk, rst_n, instr_valid, acc_wr_en, carry_wr_en, carry_wr_data;
	logic [9:0] instr_word;
	logic [3:0] y_value, acc_wr_data, acc_q;
	logic       carry_flag_q, skip_next_q, executed_q, skipped_q;
	logic [3:0] pv [4];
	int         mismatches = 0;
	int         n_tests = 0;
	pio_core pio_core_i (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
		.port_zero(pv[0]), .port_one(pv[1]), .port_two(pv[2]), .port_three(pv[3]), .y_value(y_value),
		.acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data), .carry_wr_en(carry_wr_en),
		.carry_wr_data(carry_wr_data), .acc_q(acc_q), .carry_flag_q(carry_flag_q),
		.skip_next_q(skip_next_q), .executed_q(executed_q), .skipped_q(skipped_q));
	task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(string nm, logic e, logic g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic op(logic [9:0] w);
		@(negedge clk);
		instr_valid = 1'b1;
		instr_word = w;
		@(negedge clk);
		instr_valid = 1'b0;
	endtask
	task automatic test_ports;
		// Pin change shows only after the two sync flops
		pv[0] = 4'h9;
		op(IN_PORT0);
		chk("acc", 4'h3, acc_q);
		op(IN_PORT0);
		chk("acc", 4'h9, acc_q);
		for (int i = 0; i < 4; i++) begin
			op(IN_PORT_BASE | 10'(i));
			chk("acc", pv[i], acc_q);
			chk_bit("carry", 1'h1, carry_flag_q);
			chk_bit("executed", 1'h1, executed_q);
		end
		$display("test ports done");
	endtask
	task automatic test_skip;
		y_value = 4'h0;
		op(SKIP_Y_ZERO_CODE);
		chk_bit("skip", 1'h1, skip_next_q);
		chk_bit("executed", 1'h1, executed_q);
		op(IN_PORT1);
		chk("acc", 4'hC, acc_q);
		chk_bit("skipped", 1'h1, skipped_q);
		chk_bit("executed", 1'h0, executed_q);
		chk_bit("skip", 1'h0, skip_next_q);
		y_value = 4'h3;
		op(SKIP_Y_ZERO_CODE);
		chk_bit("skip", 1'h0, skip_next_q);
		op(IN_PORT1);
		chk("acc", 4'h5, acc_q);
		// A skipped skip op must not arm another skip
		y_value = 4'h0;
		op(SKIP_Y_ZERO_CODE);
		op(SKIP_Y_ZERO_CODE);
		chk_bit("skipped", 1'h1, skipped_q);
		chk_bit("skip", 1'h0, skip_next_q);
		$display("test skip done");
	endtask
	task automatic test_immediate;
		// Outside write in the same cycle loses to the block's own load
		acc_wr_en = 1'h1;
		acc_wr_data = 4'h6;
		op(10'h072);
		acc_wr_en = 1'h0;
		chk("acc", 4'h2, acc_q);
		op(10'h000);
		op(10'h075);
		chk("acc", 4'h5, acc_q);
		chk_bit("carry", 1'h1, carry_flag_q);
		op(10'h079);
		chk("acc", 4'h5, acc_q);
		chk_bit("skipped", 1'h1, skipped_q);
		op(10'h000);
		op(10'h07F);
		chk("acc", 4'hF, acc_q);
		chk_bit("executed", 1'h1, executed_q);
		$display("test immediate done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#6000;
		mismatches++;
		test_done();
	end
	initial begin
		pv = '{4'h3, 4'h5, 4'hA, 4'hC};
		{rst_n, instr_valid, acc_wr_en, carry_wr_en, carry_wr_data} = 5'h00;
		{instr_word, y_value, acc_wr_data} = 18'h00000;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		// Carry high first, so a stray clear shows
		carry_wr_en = 1'b1;
		carry_wr_data = 1'b1;
		@(negedge clk);
		carry_wr_en = 1'b0;
		test_ports();
		test_skip();
		test_immediate();
		test_done();
	end
endmodule
